// [verilog/tdd_top.sv]
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "tdd_defines.svh"
module tdd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        smp_valid,
  input  wire logic [15:0] smp_data,
  output logic             attn
);
  localparam int NC = 14;
  localparam logic [15:0] DW [0:7] = '{`TDD_DW0, `TDD_DW1, `TDD_DW2, `TDD_DW3,
                                      `TDD_DW4, `TDD_DW5, `TDD_DW6, `TDD_DW7};

  tdd_pkg::tdd_st_e  st_q;
  tdd_pkg::tdd_st_e  st_d;
  tdd_pkg::tdd_env_e cls;
  logic [3:0]        ctrl_q;
  logic [15:0]       onth_q;
  logic [15:0]       dpth_q;
  logic [15:0]       flen_q;
  logic [2:0]        res_q;
  logic [3:0]        stat_q;
  logic [3:0]        digit_q;
  logic [31:0]       band_q;
  logic [31:0]       bacc_q;
  logic [15:0]       env_q;
  logic [15:0]       cnt_q;
  logic              act_q;
  logic              filt_q;
  logic              pend_q;
  logic              first_q;
  logic [7:0]        stc_q;
  logic              stdone_q;
  logic [31:0]       prdata_q;
  logic [31:0]       rd;
  logic [1:0]        ri;
  logic [1:0]        ci;
  logic [31:0]       rmax;
  logic [31:0]       cmax;
  wire  [15:0]       incw [NC];
  wire  [31:0]       mag  [NC];
  wire  [31:0]       lvl  [6];
  wire  [15:0]       frq  [6];
  wire  [5:0]        chgv;

  // host access is decoded apart from the sample path
  // [R19] concurrent host service
  wire       acc    = psel & penable;
  wire       wr     = acc & pwrite;
  wire [2:0] pg     = paddr[7:5];
  wire [2:0] idx    = paddr[4:2];
  wire       algn   = paddr[1:0] == 2'b00;
  wire       bank   = (idx < 3'd6) & algn;
  wire       f_hit  = (pg == `TDD_PG_FREQ) & bank;
  wire       l_hit  = (pg == `TDD_PG_LVL) & bank;
  wire       r_hit  = (pg == 3'h0) & algn;
  // [R21] one word per access
  wire       mapped = r_hit | f_hit | l_hit;
  wire       w_ctrl = wr & (paddr == `TDD_A_CTRL);
  wire       w_onth = wr & (paddr == `TDD_A_ONTH);
  wire       w_dpth = wr & (paddr == `TDD_A_DPTH);
  wire       w_flen = wr & (paddr == `TDD_A_FLEN);
  wire       w_res  = wr & (paddr == `TDD_A_RES);
  wire       w_stat = wr & (paddr == `TDD_A_STAT);

  // self test holds every working register cleared
  wire       clr     = st_q == tdd_pkg::ST_TEST;
  wire       dtmf_en = ctrl_q[`TDD_C_DTMF];
  wire       tone_en = ctrl_q[`TDD_C_TONE];
  wire       eob     = st_q == tdd_pkg::ST_EOB;
  wire       s_go    = smp_valid & (st_q == tdd_pkg::ST_IDLE);

  // [R4] host control setting
  wire [3:0]  ctrl_d = w_ctrl ? pwdata[3:0] : ctrl_q;
  wire [15:0] onth_d = w_onth ? pwdata[15:0] : onth_q;
  wire [15:0] dpth_d = w_dpth ? pwdata[15:0] : dpth_q;
  wire [15:0] flen_d = w_flen ? pwdata[15:0] : flen_q;
  wire [2:0]  res_d  = w_res ? pwdata[2:0] : res_q;

  // [R20] config back to reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 4'h0;
      onth_q <= `TDD_RST_ONTH;
      dpth_q <= `TDD_RST_DPTH;
      flen_q <= `TDD_RST_FLEN;
      res_q  <= 3'h0;
    end else begin
      ctrl_q <= clr ? {ctrl_d[`TDD_C_TEST], 3'h0} : ctrl_d;
      onth_q <= clr ? `TDD_RST_ONTH : onth_d;
      dpth_q <= clr ? `TDD_RST_DPTH : dpth_d;
      flen_q <= clr ? `TDD_RST_FLEN : flen_d;
      res_q  <= clr ? 3'h0 : res_d;
    end
  end

  // [R1] input limiter
  wire signed [15:0] sd  = smp_data;
  wire signed [15:0] lim = `TDD_LIM;
  wire signed [15:0] xc  = (sd > lim) ? lim : ((sd < -lim) ? -lim : sd);
  wire        [15:0] ax  = xc[15] ? 16'(-xc) : xc;
  wire signed [31:0] xs  = 32'(xc);

  // [R5] smoothed envelope
  wire signed [16:0] edif  = $signed({1'b0, ax}) - $signed({1'b0, env_q});
  wire        [15:0] env_n = env_q + 16'(edif >>> `TDD_ENV_SH);
  // [R6] separate onset and departure levels
  wire up = env_n > onth_q;
  wire dn = env_n < dpth_q;
  // [R5] four-way outcome
  assign cls = (!act_q & up) ? tdd_pkg::ENV_ON :
               (act_q & !pend_q & dn) ? tdd_pkg::ENV_DEP :
               act_q ? tdd_pkg::ENV_TONE : tdd_pkg::ENV_NONE;
  wire on_ev  = s_go & (cls == tdd_pkg::ENV_ON);
  wire dep_ev = s_go & (cls == tdd_pkg::ENV_DEP);
  // [R8] departure confirmed by a block
  wire dep_ok = eob & pend_q & (env_q < dpth_q);
  wire dep_now = dep_ok | (dep_ev & !filt_q);

  wire run  = filt_q | dtmf_en;
  wire last = ({1'b0, cnt_q} + 17'h1) >= {1'b0, flen_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      env_q   <= 16'h0;
      act_q   <= 1'b0;
      filt_q  <= 1'b0;
      pend_q  <= 1'b0;
      first_q <= 1'b0;
    end else if (clr) begin
      env_q   <= 16'h0;
      act_q   <= 1'b0;
      filt_q  <= 1'b0;
      pend_q  <= 1'b0;
      first_q <= 1'b0;
    end else begin
      if (s_go)
        env_q <= env_n;
      act_q   <= on_ev | (act_q & !dep_now);
      // [R13] filtering starts on onset
      filt_q  <= (on_ev & tone_en) | (filt_q & !dep_now);
      pend_q  <= (dep_ev & filt_q) | (pend_q & !eob);
      first_q <= (on_ev & tone_en) | (first_q & !eob);
    end
  end

  // [R17] block length counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_q <= 16'h0;
    else if (clr | (s_go & !run))
      cnt_q <= 16'h0;
    else if (s_go)
      cnt_q <= last ? 16'h0 : cnt_q + 16'h1;
  end

  // [R18] housekeeping before next block
  always_comb begin
    st_d = st_q;
    case (st_q)
      tdd_pkg::ST_IDLE: begin
        if (ctrl_q[`TDD_C_TEST])
          st_d = tdd_pkg::ST_TEST;
        else if (s_go & run & last)
          st_d = tdd_pkg::ST_EOB;
      end
      tdd_pkg::ST_EOB:  st_d = tdd_pkg::ST_CLR;
      tdd_pkg::ST_CLR:  st_d = tdd_pkg::ST_IDLE;
      // [R22] wait for host release
      tdd_pkg::ST_TEST: begin
        if (!ctrl_q[`TDD_C_TEST])
          st_d = tdd_pkg::ST_IDLE;
      end
      default: st_d = tdd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      st_q <= tdd_pkg::ST_IDLE;
    else
      st_q <= st_d;
  end

  // [R22] self test check run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stc_q    <= 8'h0;
      stdone_q <= 1'b0;
    end else if (!clr) begin
      stc_q    <= 8'h0;
      stdone_q <= 1'b0;
    end else if (stc_q == 8'(`TDD_ST_CYC - 1)) begin
      stdone_q <= (bacc_q == 32'h0) & (env_q == 16'h0);
    end else begin
      stc_q <= stc_q + 8'h1;
    end
  end

  // [R12] whole band accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bacc_q <= 32'h0;
    else if (clr | (st_q == tdd_pkg::ST_CLR))
      bacc_q <= 32'h0;
    else if (s_go & run)
      bacc_q <= bacc_q + 32'(ax);
  end

  // correlators: slots 0..5 programmable, 6..13 fixed dialing pairs
  for (genvar i = 0; i < NC; i++) begin : g_c
    logic [15:0] ph_q;
    logic [31:0] ai_q;
    logic [31:0] aq_q;
    wire         sp = ~ph_q[15];
    wire         cp = ph_q[15] ~^ ph_q[14];
    wire  [31:0] ia = ai_q[31] ? 32'(-ai_q) : ai_q;
    wire  [31:0] qa = aq_q[31] ? 32'(-aq_q) : aq_q;
    wire  [32:0] sm = {1'b0, ia} + {1'b0, qa};
    // [R2] dialing pair slots only while enabled
    wire         en = s_go & ((i < 6) ? run : dtmf_en);
    if (i < 6) begin : g_p
      logic [15:0] fq_q;
      logic [31:0] lv_q;
      wire         z  = dtmf_en & (i >= 3);
      wire  [31:0] df = (mag[i] > lv_q) ? mag[i] - lv_q : lv_q - mag[i];
      // [R9] programmable search frequency
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          fq_q <= 16'h0;
        else if (clr)
          fq_q <= 16'h0;
        else if (wr & f_hit & (idx == 3'(i)))
          fq_q <= pwdata[15:0];
      end
      // [R10] [R11] level report per slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          lv_q <= 32'h0;
        else if (clr)
          lv_q <= 32'h0;
        else if (eob)
          lv_q <= z ? 32'h0 : mag[i];
      end
      assign incw[i] = fq_q;
      assign frq[i]  = fq_q;
      assign lvl[i]  = lv_q;
      assign chgv[i] = !z & (df > (lv_q >> 2));
    end else begin : g_d
      assign incw[i] = DW[i-6];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ph_q <= 16'h0;
        ai_q <= 32'h0;
        aq_q <= 32'h0;
      end else if (clr | (st_q == tdd_pkg::ST_CLR)) begin
        ph_q <= 16'h0;
        ai_q <= 32'h0;
        aq_q <= 32'h0;
      end else if (en) begin
        ph_q <= ph_q + incw[i];
        ai_q <= sp ? ai_q + xs : ai_q - xs;
        aq_q <= cp ? aq_q + xs : aq_q - xs;
      end
    end
    // [R7] power per frequency
    assign mag[i] = 32'(sm >> res_q);
  end

  // [R3] strongest row and column
  always_comb begin
    ri   = 2'h0;
    ci   = 2'h0;
    rmax = mag[6];
    cmax = mag[10];
    for (int k = 1; k < 4; k++) begin
      if (mag[6+k] > rmax) begin
        rmax = mag[6+k];
        ri   = 2'(k);
      end
      if (mag[10+k] > cmax) begin
        cmax = mag[10+k];
        ci   = 2'(k);
      end
    end
  end

  // twist limited to a factor of four either way
  // [R3] deviation template check
  wire dt_ok = dtmf_en & (rmax >= 32'(onth_q)) & (cmax >= 32'(onth_q)) &
               ({2'b0, rmax} < {cmax, 2'b0}) & ({2'b0, cmax} < {rmax, 2'b0});

  // [R14] arrival after first block
  wire s_arr = eob & first_q & filt_q & !pend_q;
  // [R15] departure flagged once confirmed
  wire s_dep = dep_ok;
  wire s_chg = eob & filt_q & !first_q & (|chgv);
  wire s_dig = eob & dt_ok;
  wire [3:0] setv = {s_dig, s_chg, s_dep, s_arr};
  wire [3:0] w1c  = w_stat ? pwdata[3:0] : 4'h0;

  // a new event beats a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stat_q <= 4'h0;
    else if (clr)
      stat_q <= 4'h0;
    else
      stat_q <= (stat_q & ~w1c) | setv;
  end

  // [R12] [R18] levels latched at block end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      band_q  <= 32'h0;
      digit_q <= 4'h0;
    end else if (clr) begin
      band_q  <= 32'h0;
      digit_q <= 4'h0;
    end else if (eob) begin
      band_q  <= 32'(bacc_q >> res_q);
      if (dt_ok)
        digit_q <= {ri, ci};
    end
  end

  // [R16] change alert gated by option
  assign attn = stat_q[`TDD_S_ARR] | stat_q[`TDD_S_DEP] | stat_q[`TDD_S_DIG] |
                (stat_q[`TDD_S_CHG] & ctrl_q[`TDD_C_CHG]);

  always_comb begin
    rd = 32'h0;
    if (f_hit)
      rd = {16'h0, frq[idx]};
    else if (l_hit)
      rd = lvl[idx];
    else begin
      case (paddr)
        `TDD_A_CTRL:  rd = {28'h0, ctrl_q};
        `TDD_A_ONTH:  rd = {16'h0, onth_q};
        `TDD_A_DPTH:  rd = {16'h0, dpth_q};
        `TDD_A_FLEN:  rd = {16'h0, flen_q};
        `TDD_A_RES:   rd = {29'h0, res_q};
        `TDD_A_STAT:  rd = {26'h0, stdone_q, act_q, stat_q};
        `TDD_A_DIGIT: rd = {28'h0, digit_q};
        `TDD_A_BAND:  rd = band_q;
        default:      rd = 32'h0;
      endcase
    end
  end

  // read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (psel & !penable)
      prdata_q <= rd;
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = acc & !mapped;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CLAMP: assert property (smp_valid |-> (xc <= lim) && (xc >= -lim)) // [R1]
    else $error("sample not limited");
  AST_ONSET: assert property (on_ev && tone_en && !clr |=> filt_q && first_q) // [R13]
    else $error("filtering not started on onset");
  AST_BLOCK: assert property (s_go && run && last && !ctrl_q[3] |=> eob) // [R17]
    else $error("block end missed");
  AST_HOUSE: assert property (eob |=> st_q == tdd_pkg::ST_CLR ##1 bacc_q == 32'h0) // [R18]
    else $error("accumulators not cleared after block");
  AST_ARRIVE: assert property (s_arr |=> stat_q[0] && !first_q) // [R14]
    else $error("arrival bit not set");
  AST_ZERO: assert property (eob && dtmf_en |=> lvl[3] == 0 && lvl[4] == 0 && lvl[5] == 0) // [R11]
    else $error("unused slots not zero");
  AST_DEPART: assert property (eob && pend_q && env_q < dpth_q |=> stat_q[1] && !filt_q) // [R15]
    else $error("departure not confirmed");
  AST_CHGMASK: assert property (!ctrl_q[2] && stat_q == 4'h4 |-> !attn) // [R16]
    else $error("change alert not masked");
  AST_TEST: assert property (clr |=> env_q == 0 && !act_q && stat_q == 0) // [R20]
    else $error("self test left working data");
  AST_TESTRUN: assert property ($rose(clr) |-> ##[1:25] (stdone_q || !clr)) // [R22]
    else $error("self test never finished");
  AST_SLVERR: assert property (acc && !mapped |-> pslverr && pready) // [R19]
    else $error("unmapped access not refused");

  COV_ARRIVE: cover property (s_arr);
  COV_DIGIT: cover property (s_dig);
  COV_TEST: cover property (clr && stdone_q);
endmodule : tdd_top

// [verilog/tdd_defines.svh]
`ifndef TDD_DEFINES_SVH
`define TDD_DEFINES_SVH
// Operation
// [R1] clamp samples beyond maximum input level
// [R2] route sample to digit receiver when enabled
// [R3] digit receiver validates pairs, then envelope; the code checks pair levels and twist only, not the envelope
// [R4] host enables or disables digit receiver
// [R5] envelope smoothed, four outcome classification
// [R6] separate onset and departure thresholds
// [R7] measure total power and six frequencies
// [R8] confirm onset/departure before status bits
// [R9] programmable frequency, bandwidth, resolution, thresholds
// [R10] digit receiver off: six levels reported
// [R11] digit receiver on: three slots read zero
// [R12] report whole band power
// [R13] block filtering starts at tone onset
// [R14] first block end sets arrival bit
// [R15] confirmed departure can alert host
// [R16] change alert only when option enabled
// [R17] block length from filter length register
// [R18] end of block housekeeping before next
// [R19] sample and host access serviced apart
// [R20] self test restores reset state
// [R21] host reaches one byte register per access; the APB port reaches one 32-bit word register per access
// [R22] self test runs checks, awaits release

`define TDD_A_CTRL  8'h00
`define TDD_A_ONTH  8'h04
`define TDD_A_DPTH  8'h08
`define TDD_A_FLEN  8'h0c
`define TDD_A_RES   8'h10
`define TDD_A_STAT  8'h14
`define TDD_A_DIGIT 8'h18
`define TDD_A_BAND  8'h1c
`define TDD_PG_FREQ 3'h1
`define TDD_PG_LVL  3'h2

`define TDD_C_DTMF  0
`define TDD_C_TONE  1
`define TDD_C_CHG   2
`define TDD_C_TEST  3
`define TDD_S_ARR   0
`define TDD_S_DEP   1
`define TDD_S_CHG   2
`define TDD_S_DIG   3

`define TDD_RST_ONTH 16'h0200
`define TDD_RST_DPTH 16'h0100
`define TDD_RST_FLEN 16'h00cd
`define TDD_LIM      16'h1fff
`define TDD_ENV_SH   4

`define TDD_CLK_MHZ  10
`define TDD_ST_US    2
`define TDD_ST_CYC   (`TDD_ST_US * `TDD_CLK_MHZ)

`define TDD_DW0 16'h164d
`define TDD_DW1 16'h18a4
`define TDD_DW2 16'h1b43
`define TDD_DW3 16'h1e1d
`define TDD_DW4 16'h26b0
`define TDD_DW5 16'h2ac1
`define TDD_DW6 16'h2f44
`define TDD_DW7 16'h3442
`endif

// [verilog/tdd_pkg.sv]
package tdd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EOB  = 2'b01,
    ST_CLR  = 2'b10,
    ST_TEST = 2'b11
  } tdd_st_e;
  typedef enum logic [1:0] {
    ENV_NONE = 2'b00,
    ENV_ON   = 2'b01,
    ENV_DEP  = 2'b10,
    ENV_TONE = 2'b11
  } tdd_env_e;
endpackage : tdd_pkg

// [testbench/tdd_codec_model.sv]
`timescale 1ns/1ps
module tdd_codec_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic [15:0] amp,
  output logic             smp_valid,
  output logic [15:0]      smp_data
);
  logic [1:0] cnt_q;
  logic       neg_q;
  // one strobe every four cycles keeps the three cycle spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 2'h0;
      neg_q     <= 1'b0;
      smp_valid <= 1'b0;
      smp_data  <= 16'h0;
    end else begin
      cnt_q     <= cnt_q + 2'h1;
      smp_valid <= run && (cnt_q == 2'h3);
      if (run && (cnt_q == 2'h3)) begin
        neg_q    <= !neg_q;
        smp_data <= neg_q ? 16'h0 - amp : amp;
      end else begin
        // released line: never hold the old sample
        smp_data <= ~smp_data;
      end
    end
  end
endmodule : tdd_codec_model

// [testbench/test_tone_and_dual_tone_detector.sv]
`timescale 1ns/1ps
`include "tdd_defines.svh"
module test_tone_and_dual_tone_detector;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        smp_valid;
  logic [15:0] smp_data;
  logic        attn;
  logic        run;
  logic [15:0] amp;
  logic [31:0] rd;
  logic        err;
  logic [31:0] flen;
  logic [31:0] res;
  logic [31:0] th;
  integer      n_errors;
  integer      num_checks;
  integer      seed;
  integer      i;

  tdd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .smp_valid(smp_valid), .smp_data(smp_data), .attn(attn));
  tdd_codec_model codec (.pclk(pclk), .presetn(presetn), .run(run), .amp(amp),
    .smp_valid(smp_valid), .smp_data(smp_data));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // every sample clamps to full scale, so a block sums to length times limit
  function automatic logic [31:0] exp_band(input logic [31:0] n, input logic [31:0] s);
    return (n * 32'(`TDD_LIM)) >> s;
  endfunction : exp_band

  // zero phase slot over an odd block: one clamped sample left in each arm
  function automatic logic [31:0] exp_lvl(input logic [31:0] s);
    return (32'(`TDD_LIM) << 1) >> s;
  endfunction : exp_lvl

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll status until a bit reaches a value, bounded
  task automatic wait_stat(input integer b, input logic v);
    integer k;
    k = 0;
    do begin
      apb(1'b0, `TDD_A_STAT, 32'h0);
      k = k + 1;
    end while (rd[b] !== v && k < 300);
  endtask : wait_stat

  task automatic chk_attn(input logic v);
    @(negedge pclk);
    check({31'h0, attn}, {31'h0, v}); // alert line
  endtask : chk_attn

  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors = n_errors + 1;
    complete_run();
  end

  initial begin
    seed = 58;
    n_errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    run = 1'b0;
    amp = 16'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TDD_A_CTRL, 32'h0);
    check(rd, 32'h0); // receivers off at reset
    apb(1'b0, `TDD_A_FLEN, 32'h0);
    check(rd, 32'h0000_00cd); // block length
    chk_attn(1'b0); // quiet after reset
    // unmapped place refuses
    apb(1'b1, 8'h3c, 32'hffff_ffff);
    check({31'h0, err}, 32'h1); // unmapped write refused
    apb(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0); // unmapped read returns zero
    // thresholds kept apart
    th = 32'h100 + ($random(seed) & 32'h3ff);
    apb(1'b1, `TDD_A_ONTH, th);
    apb(1'b1, `TDD_A_DPTH, 32'h80);
    apb(1'b0, `TDD_A_ONTH, 32'h0);
    check(rd, th); // onset level
    apb(1'b0, `TDD_A_DPTH, 32'h0);
    check(rd, 32'h80); // departure level
    // tone path off: loud input gives no arrival
    amp <= 16'h2000 + ($random(seed) & 16'h3fff);
    run <= 1'b1;
    repeat (200) @(posedge pclk);
    apb(1'b0, `TDD_A_STAT, 32'h0);
    check(rd[0], 1'b0); // no tone path
    amp <= 16'h0;
    repeat (600) @(posedge pclk);
    // arrival with clamped input, random block length and resolution
    // odd length keeps the per-slot level predictable
    flen = 5 + 2 * ($random(seed) & 3);
    res = $random(seed) & 7;
    apb(1'b1, `TDD_A_FLEN, flen);
    apb(1'b1, `TDD_A_RES, res);
    apb(1'b1, `TDD_A_CTRL, 32'h2);
    amp <= 16'h2000 + ($random(seed) & 16'h3fff);
    wait_stat(0, 1'b1);
    check(rd[0], 1'b1); // arrival
    check(rd[4], 1'b1); // tone active
    chk_attn(1'b1); // host alerted
    apb(1'b0, `TDD_A_BAND, 32'h0);
    check(rd, exp_band(flen, res)); // limited band sum
    // digit receiver off: all six slots report
    for (i = 0; i < 6; i = i + 1) begin
      apb(1'b0, 8'h40 + 8'(4 * i), 32'h0);
      check(rd, exp_lvl(res)); // six levels
    end
    // write one clears arrival
    apb(1'b1, `TDD_A_STAT, 32'hf);
    apb(1'b0, `TDD_A_STAT, 32'h0);
    check(rd[0], 1'b0); // status cleared
    chk_attn(1'b0); // alert released
    // silence confirms departure
    amp <= 16'h0;
    wait_stat(1, 1'b1);
    check(rd[1], 1'b1); // departure
    check(rd[4], 1'b0); // tone gone
    chk_attn(1'b1); // host alerted
    apb(1'b1, `TDD_A_STAT, 32'hf);
    // digit receiver on: upper three slots read zero
    apb(1'b1, `TDD_A_CTRL, 32'h3);
    amp <= 16'h2000 + ($random(seed) & 16'h3fff);
    wait_stat(0, 1'b1);
    check(rd[0], 1'b1); // arrival, digit path on
    for (i = 3; i < 6; i = i + 1) begin
      apb(1'b0, 8'h40 + 8'(4 * i), 32'h0);
      check(rd, 32'h0); // unused slots
    end
    // self test wipes settings, waits for release
    run <= 1'b0;
    th = $random(seed) & 32'hffff;
    apb(1'b1, 8'h28, th);
    apb(1'b0, 8'h28, 32'h0);
    check(rd, th); // search frequency kept
    apb(1'b1, `TDD_A_CTRL, 32'hf);
    wait_stat(5, 1'b1);
    check(rd[5], 1'b1); // self test done
    apb(1'b0, `TDD_A_ONTH, 32'h0);
    check(rd, 32'h200); // reset state
    apb(1'b1, `TDD_A_CTRL, 32'h0);
    apb(1'b0, `TDD_A_FLEN, 32'h0);
    check(rd, 32'h0000_00cd); // reset state
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h0); // frequency wiped
    apb(1'b0, `TDD_A_STAT, 32'h0);
    check(rd[3:0], 4'h0); // status wiped
    complete_run();
  end
endmodule : test_tone_and_dual_tone_detector
